// *** rtl/ppl_pin_cell.sv ***
`timescale 1ns/10ps
`default_nettype none
// one pin: latch, direction and alternate-function mux
module ppl_pin_cell (
    // configuration
    input wire logic latch,
    input wire logic dir_in,
    input wire logic alt_mode,
    // alternate side
    input wire logic alt_out,
    input wire logic alt_oe,
    // pin
    output logic pin_out,
    output logic pin_oe
);
    // alternate function overrides latch and direction else plain port
    assign pin_out = alt_mode ? alt_out : latch;
    assign pin_oe = alt_mode ? alt_oe : ~dir_in;
endmodule
`default_nettype wire

// *** rtl/ppl_pkg.sv ***
package ppl_pkg;
    // register offsets on the register port (word indices)
    localparam logic [3:0] OFS_U_LATCH = 4'h0;
    localparam logic [3:0] OFS_U_DIR = 4'h1;
    localparam logic [3:0] OFS_U_MODE = 4'h2;
    localparam logic [3:0] OFS_U_FUNC = 4'h3;
    localparam logic [3:0] OFS_U_ODRAIN = 4'h4;
    localparam logic [3:0] OFS_U_RISE = 4'h5;
    localparam logic [3:0] OFS_U_FALL = 4'h6;
    localparam logic [3:0] OFS_C_LATCH = 4'h8;
    localparam logic [3:0] OFS_C_DIR = 4'h9;
    localparam logic [3:0] OFS_C_MODE = 4'hA;
    localparam logic [3:0] OFS_IRQ_FLAG = 4'hB;
    // upper port pin positions
    localparam int ODRAIN_LO = 11;
    localparam int ODRAIN_HI = 12;
    localparam int IRQ_PIN_BASE = 13;
    localparam int NUM_IRQ = 3;
    // reset values: ports come up as plain inputs
    localparam logic [15:0] RST_LATCH = 16'h0000;
    localparam logic [15:0] RST_DIR = 16'hFFFF;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] PORT_WIDTH = 16'h0010;
    // bus-control port: 0 wait,1 sysclk out,2 hold ack,3 hold req,4..7 chip selects,
    // 8 wr lo,9 wr hi,10 rd,11 addr strobe,12..19 upper addr 16..23,20..35 addr/data
    localparam int CTRL_PINS = 36;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ppl_bus_t;
endpackage

// *** rtl/ppl_port_pin_latch_mux.sv ***
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ppl_port_pin_latch_mux
    import ppl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire ppl_bus_t bus,
    output logic [15:0] rdata,
    // upper port pins
    input wire logic [15:0] up_pin_in,
    output logic [15:0] up_pin_out,
    output logic [15:0] up_pin_oe,
    // upper port alternates: address, serial and interrupt
    input wire logic [15:0] addr_low_out,
    input wire logic csi_b_serial_out,
    input wire logic csi_b_serial_clock_out,
    input wire logic csi_b_serial_clock_oe,
    output logic csi_b_serial_in,
    output logic csi_b_serial_clock_in,
    output logic [NUM_IRQ-1:0] ext_irq_pulse,
    // bus-control port pins
    input wire logic [CTRL_PINS-1:0] ctrl_pin_in,
    output logic [CTRL_PINS-1:0] ctrl_pin_out,
    output logic [CTRL_PINS-1:0] ctrl_pin_oe,
    // bus-controller alternates
    input wire logic [CTRL_PINS-1:0] bus_alt_out,
    input wire logic [CTRL_PINS-1:0] bus_alt_oe,
    output logic [CTRL_PINS-1:0] bus_alt_in
);
    logic [15:0] port_output_latch;
    logic [15:0] direction_control;
    logic [15:0] upper_port_mode_control;
    logic [15:0] upper_port_function_select;
    logic [15:0] open_drain_select;
    logic [15:0] rising_edge_select;
    logic [15:0] falling_edge_select;
    logic [CTRL_PINS-1:0] ctrl_latch;
    logic [CTRL_PINS-1:0] ctrl_dir;
    logic [CTRL_PINS-1:0] alt_mode_control;
    logic [NUM_IRQ-1:0] irq_prev;
    logic [NUM_IRQ-1:0] irq_flag;
    logic [15:0] next_rdata;

    // write decode
    wire wr_u_latch = bus.wr && bus.addr == OFS_U_LATCH;
    wire wr_u_dir = bus.wr && bus.addr == OFS_U_DIR;
    wire wr_u_mode = bus.wr && bus.addr == OFS_U_MODE;
    wire wr_u_func = bus.wr && bus.addr == OFS_U_FUNC;
    wire wr_u_od = bus.wr && bus.addr == OFS_U_ODRAIN;
    wire wr_u_rise = bus.wr && bus.addr == OFS_U_RISE;
    wire wr_u_fall = bus.wr && bus.addr == OFS_U_FALL;
    wire wr_c_latch = bus.wr && bus.addr == OFS_C_LATCH;
    wire wr_c_dir = bus.wr && bus.addr == OFS_C_DIR;
    wire wr_c_mode = bus.wr && bus.addr == OFS_C_MODE;
    wire wr_flag = bus.wr && bus.addr == OFS_IRQ_FLAG;

    // latches change only on their own write; read-modify-write arrives as a plain
    // write of a full word, so input-mode bits just take whatever software wrote
    always_ff @(posedge clk) begin
        if (reset) begin
            port_output_latch <= RST_LATCH;
            direction_control <= RST_DIR;
            upper_port_mode_control <= RST_ZERO;
            upper_port_function_select <= RST_ZERO;
            open_drain_select <= RST_ZERO;
            rising_edge_select <= RST_ZERO;
            falling_edge_select <= RST_ZERO;
        end else begin
            if (wr_u_latch) port_output_latch <= bus.wdata;
            if (wr_u_dir) direction_control <= bus.wdata;
            if (wr_u_mode) upper_port_mode_control <= bus.wdata;
            if (wr_u_func) upper_port_function_select <= bus.wdata;
            if (wr_u_od) open_drain_select <= bus.wdata;
            if (wr_u_rise) rising_edge_select <= bus.wdata;
            if (wr_u_fall) falling_edge_select <= bus.wdata;
        end
    end

    // bus-control port registers, 36 bits split over three words
    logic [1:0] c_sel;
    // low two data bits pick the word lane; upper bits carry data
    assign c_sel = bus.wdata[1:0];
    logic [CTRL_PINS-1:0] c_wmask, c_wval;
    always_comb begin
        c_wmask = '0;
        c_wval = '0;
        unique case (c_sel)
            2'h0: begin
                c_wmask = {{(CTRL_PINS-14){1'b0}}, 14'h3FFF};
                c_wval = {{(CTRL_PINS-14){1'b0}}, bus.wdata[15:2]};
            end
            2'h1: begin
                c_wmask = {{(CTRL_PINS-28){1'b0}}, 14'h3FFF, 14'h0000};
                c_wval = {{(CTRL_PINS-28){1'b0}}, bus.wdata[15:2], 14'h0000};
            end
            2'h2: begin
                c_wmask = {8'hFF, 28'h0000000};
                c_wval = {bus.wdata[9:2], 28'h0000000};
            end
            default: begin
                c_wmask = '0;
                c_wval = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_latch <= '0;
            ctrl_dir <= '1;
            alt_mode_control <= '0;
        end else begin
            if (wr_c_latch) ctrl_latch <= (ctrl_latch & ~c_wmask) | c_wval;
            if (wr_c_dir) ctrl_dir <= (ctrl_dir & ~c_wmask) | c_wval;
            if (wr_c_mode) alt_mode_control <= (alt_mode_control & ~c_wmask) | c_wval;
        end
    end

    // upper port alternate outputs: function 0 is address, 1 is serial or interrupt
    logic [15:0] up_alt_out, up_alt_oe;
    always_comb begin
        up_alt_out = addr_low_out;
        up_alt_oe = ~upper_port_function_select;
        // serial data out and clock on pins 11 and 12 ignore open drain
        if (upper_port_function_select[ODRAIN_LO]) begin
            up_alt_out[ODRAIN_LO] = csi_b_serial_out;
            up_alt_oe[ODRAIN_LO] = 1'b1;
        end
        if (upper_port_function_select[ODRAIN_HI]) begin
            up_alt_out[ODRAIN_HI] = csi_b_serial_clock_out;
            up_alt_oe[ODRAIN_HI] = csi_b_serial_clock_oe;
        end
    end

    // open drain applies only to plain port use: drive low, release high
    logic [15:0] up_cell_out, up_cell_oe;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_up
            ppl_pin_cell u_cell (
                .latch(port_output_latch[gi]),
                .dir_in(direction_control[gi]),
                .alt_mode(upper_port_mode_control[gi]),
                .alt_out(up_alt_out[gi]),
                .alt_oe(up_alt_oe[gi]),
                .pin_out(up_cell_out[gi]),
                .pin_oe(up_cell_oe[gi])
            );
            assign up_pin_out[gi] = up_cell_out[gi];
            assign up_pin_oe[gi] = up_cell_oe[gi] &&
                !(open_drain_select[gi] && !upper_port_mode_control[gi] && up_cell_out[gi]);
        end
        for (gi = 0; gi < CTRL_PINS; gi++) begin : g_ctrl
            ppl_pin_cell u_cell (
                .latch(ctrl_latch[gi]),
                .dir_in(ctrl_dir[gi]),
                .alt_mode(alt_mode_control[gi]),
                .alt_out(bus_alt_out[gi]),
                .alt_oe(bus_alt_oe[gi]),
                .pin_out(ctrl_pin_out[gi]),
                .pin_oe(ctrl_pin_oe[gi])
            );
            // inputs reach the bus controller only in alternate mode
            assign bus_alt_in[gi] = alt_mode_control[gi] & ctrl_pin_in[gi];
        end
    endgenerate

    // serial inputs from pins 10 and 12
    assign csi_b_serial_in = upper_port_mode_control[10] & upper_port_function_select[10]
        & up_pin_in[10];
    assign csi_b_serial_clock_in = up_pin_in[ODRAIN_HI];

    // external interrupt edge detection on pins 13..15
    logic [NUM_IRQ-1:0] irq_en, irq_lvl, irq_edge;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
            assign irq_en[gi] = upper_port_mode_control[IRQ_PIN_BASE+gi]
                && upper_port_function_select[IRQ_PIN_BASE+gi];
            assign irq_lvl[gi] = up_pin_in[IRQ_PIN_BASE+gi];
            assign irq_edge[gi] = irq_en[gi] && (
                (rising_edge_select[IRQ_PIN_BASE+gi] && irq_lvl[gi] && !irq_prev[gi]) ||
                (falling_edge_select[IRQ_PIN_BASE+gi] && !irq_lvl[gi] && irq_prev[gi]));
        end
    endgenerate

    // edge flags: a new edge wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_prev <= '0;
            irq_flag <= '0;
            ext_irq_pulse <= '0;
        end else begin
            irq_prev <= irq_lvl;
            ext_irq_pulse <= irq_edge;
            irq_flag <= (irq_flag & ~(wr_flag ? bus.wdata[NUM_IRQ-1:0] : '0)) | irq_edge;
        end
    end

    // read mux: output bits read the latch, input bits read the pin
    wire [15:0] up_read = (port_output_latch & ~direction_control)
        | (up_pin_in & direction_control);
    wire [CTRL_PINS-1:0] c_read = (ctrl_latch & ~ctrl_dir) | (ctrl_pin_in & ctrl_dir);
    always_comb begin
        next_rdata = 16'h0000;
        unique case (bus.addr)
            OFS_U_LATCH: next_rdata = up_read;
            OFS_U_DIR: next_rdata = direction_control;
            OFS_U_MODE: next_rdata = upper_port_mode_control;
            OFS_U_FUNC: next_rdata = upper_port_function_select;
            OFS_U_ODRAIN: next_rdata = open_drain_select;
            OFS_U_RISE: next_rdata = rising_edge_select;
            OFS_U_FALL: next_rdata = falling_edge_select;
            OFS_C_LATCH: next_rdata = c_read[15:0];
            OFS_C_DIR: next_rdata = ctrl_dir[15:0];
            OFS_C_MODE: next_rdata = alt_mode_control[15:0];
            OFS_IRQ_FLAG: next_rdata = {13'h0000, irq_flag};
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) rdata <= 16'h0000;
        else rdata <= bus.rd ? next_rdata : 16'h0000;
    end

    // assertions
    property p_alt_override;
        @(posedge clk) disable iff (reset)
        upper_port_mode_control[0] |-> up_pin_out[0] == addr_low_out[0] || up_alt_oe[0] == 1'b0;
    endproperty
    a_alt_override: assert property (p_alt_override) else $error("alt mode not taken");

    property p_input_float;
        @(posedge clk) disable iff (reset)
        !upper_port_mode_control[1] && direction_control[1] |-> !up_pin_oe[1];
    endproperty
    a_input_float: assert property (p_input_float) else $error("input pin driven");

    property p_write_latch;
        @(posedge clk) disable iff (reset)
        wr_u_latch |=> port_output_latch == $past(bus.wdata);
    endproperty
    a_write_latch: assert property (p_write_latch) else $error("latch not written");

    property p_hold_latch;
        @(posedge clk) disable iff (reset)
        !wr_u_latch |=> $stable(port_output_latch);
    endproperty
    a_hold_latch: assert property (p_hold_latch) else $error("latch changed");

    property p_drive_latch;
        @(posedge clk) disable iff (reset)
        !upper_port_mode_control[2] && !direction_control[2] && !open_drain_select[2]
        |-> up_pin_oe[2] && up_pin_out[2] == port_output_latch[2];
    endproperty
    a_drive_latch: assert property (p_drive_latch) else $error("output not driven");

    property p_read_out;
        @(posedge clk) disable iff (reset)
        bus.rd && bus.addr == OFS_U_LATCH && direction_control == 16'h0000
        |=> rdata == $past(port_output_latch);
    endproperty
    a_read_out: assert property (p_read_out) else $error("read not latch");

    property p_read_in;
        @(posedge clk) disable iff (reset)
        bus.rd && bus.addr == OFS_U_LATCH && direction_control == 16'hFFFF
        |=> rdata == $past(up_pin_in);
    endproperty
    a_read_in: assert property (p_read_in) else $error("read not pin");

    property p_irq_rise;
        @(posedge clk) disable iff (reset)
        irq_en[0] && rising_edge_select[IRQ_PIN_BASE] && irq_lvl[0] && !irq_prev[0]
        |=> ext_irq_pulse[0] && irq_flag[0];
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("edge missed");

    property p_write_lane;
        @(posedge clk) disable iff (reset)
        wr_c_latch && bus.wdata[1:0] == 2'h0 |=> ctrl_latch[13:0] == $past(bus.wdata[15:2]);
    endproperty
    a_write_lane: assert property (p_write_lane) else $error("lane write lost");

    property p_ctrl_alt;
        @(posedge clk) disable iff (reset)
        alt_mode_control[0]
        |-> ctrl_pin_oe[0] == bus_alt_oe[0] && ctrl_pin_out[0] == bus_alt_out[0];
    endproperty
    a_ctrl_alt: assert property (p_ctrl_alt) else $error("bus pin not handed over");

    property p_ctrl_plain;
        @(posedge clk) disable iff (reset)
        !alt_mode_control[4] && !ctrl_dir[4]
        |-> ctrl_pin_oe[4] && ctrl_pin_out[4] == ctrl_latch[4];
    endproperty
    a_ctrl_plain: assert property (p_ctrl_plain) else $error("bus pin not plain output");

    property p_irq_fall;
        @(posedge clk) disable iff (reset)
        irq_en[2] && falling_edge_select[IRQ_PIN_BASE+2] && !irq_lvl[2] && irq_prev[2]
        |=> ext_irq_pulse[2] && irq_flag[2];
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("falling edge missed");

    property p_irq_quiet;
        @(posedge clk) disable iff (reset)
        !irq_en[1] |=> !ext_irq_pulse[1];
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("pulse on plain pin");

    property p_flag_clear;
        @(posedge clk) disable iff (reset)
        wr_flag && bus.wdata[0] && !irq_edge[0] |=> !irq_flag[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_rmw_out;
        @(posedge clk) disable iff (reset)
        wr_u_latch && !upper_port_mode_control[3] && !direction_control[3]
        && !open_drain_select[3] |=> up_pin_oe[3] && up_pin_out[3] == $past(bus.wdata[3]);
    endproperty
    a_rmw_out: assert property (p_rmw_out) else $error("new latch not on pin");

    property p_write_in;
        @(posedge clk) disable iff (reset)
        wr_u_latch && !upper_port_mode_control[1] && direction_control[1]
        |=> !up_pin_oe[1] && port_output_latch[1] == $past(bus.wdata[1]);
    endproperty
    a_write_in: assert property (p_write_in) else $error("input write misbehaved");
endmodule
`default_nettype wire

// *** tb/ppl_board.sv ***
`timescale 1ns/10ps
`default_nettype none
// board side of a pin group: drives only where the chip leaves the pin free
module ppl_board #(parameter int W = 16) (
    // clock
    input wire logic clk,
    // chip side
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    // board drivers
    input wire logic [W-1:0] drv_en,
    input wire logic [W-1:0] drv_val,
    output logic [W-1:0] pin_in
);
    logic flt = 1'b0;
    // no pull-ups here, so a free pin wanders rather than keeping its last level
    always @(posedge clk) begin
        flt <= ~flt;
    end
    // the chip wins where it drives, board devices elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val)
        | (~pin_oe & ~drv_en & {W{flt}});
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ppl_pkg::*;
    localparam logic [3:0] RA[12] = '{OFS_U_DIR, OFS_U_MODE, OFS_U_FUNC, OFS_U_ODRAIN,
        OFS_U_RISE, OFS_U_FALL, OFS_C_LATCH, OFS_C_DIR, OFS_C_MODE, OFS_IRQ_FLAG, 4'h7, 4'hF};
    logic clk = 1'b0;
    logic reset = 1'b1;
    ppl_bus_t bus = '0;
    logic [15:0] rdata, up_pin_in, up_pin_out, up_pin_oe;
    logic [15:0] addr_low_out = '0;
    logic [15:0] u_val = '0;
    logic csi_b_serial_out = 1'b0;
    logic csi_b_serial_clock_out = 1'b0;
    logic csi_b_serial_clock_oe = 1'b0;
    logic csi_b_serial_in, csi_b_serial_clock_in;
    logic [NUM_IRQ-1:0] ext_irq_pulse;
    logic [CTRL_PINS-1:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe, bus_alt_in;
    logic [CTRL_PINS-1:0] bus_alt_out = '0;
    logic [CTRL_PINS-1:0] bus_alt_oe = '0;
    logic [CTRL_PINS-1:0] c_val = '0;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int pc[3];

    ppl_port_pin_latch_mux dut (.clk, .reset, .bus, .rdata, .up_pin_in, .up_pin_out,
        .up_pin_oe, .addr_low_out, .csi_b_serial_out, .csi_b_serial_clock_out,
        .csi_b_serial_clock_oe, .csi_b_serial_in, .csi_b_serial_clock_in, .ext_irq_pulse,
        .ctrl_pin_in, .ctrl_pin_out, .ctrl_pin_oe, .bus_alt_out, .bus_alt_oe, .bus_alt_in);
    ppl_board #(.W(16)) up_brd (.clk(clk), .pin_out(up_pin_out), .pin_oe(up_pin_oe),
        .drv_en(16'hFFFF), .drv_val(u_val), .pin_in(up_pin_in));
    ppl_board #(.W(CTRL_PINS)) c_brd (.clk(clk), .pin_out(ctrl_pin_out), .pin_oe(ctrl_pin_oe),
        .drv_en({CTRL_PINS{1'b1}}), .drv_val(c_val), .pin_in(ctrl_pin_in));

    always #20 clk = ~clk;
    // hang guard and interrupt pulse tally
    always @(posedge clk) begin
        cyc++;
        for (int i = 0; i < 3; i++) if (ext_irq_pulse[i] === 1'b1) pc[i]++;
        if (cyc > 5000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic c16(input logic [15:0] got, input logic [15:0] exp);
        chk({20'h0, got}, {20'h0, exp});
    endtask
    // one-cycle strobes, changed just after the edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 c16(rdata, e);
    endtask
    // bus-control registers go in three lanes: two of fourteen bits and one of eight
    task automatic wctrl(input logic [3:0] a, input logic [35:0] v);
        wr(a, {v[13:0], 2'h0});
        wr(a, {v[27:14], 2'h1});
        wr(a, {6'h00, v[35:28], 2'h2});
    endtask
    // pulse tally has one writer; compare against a snapshot instead of clearing it
    task automatic edge3(input logic [2:0] lvl, input logic [2:0] e);
        int p0[3];
        @(posedge clk);
        u_val[15:13] <= lvl;
        #1 p0 = pc;
        repeat (5) @(posedge clk);
        #1;
        for (int i = 0; i < 3; i++) chk(36'(pc[i] - p0[i]), {35'h0, e[i]});
    endtask
    // input bits show the pins, output bits the latch
    function automatic logic [15:0] port_rd(input logic [15:0] lat, dir, pin);
        return (lat & ~dir) | (pin & dir);
    endfunction

    initial begin
        logic [15:0] lat, dir, v;
        logic [35:0] r;
        void'($urandom(32'h387bf1c3));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        wr(4'h7, 16'hFFFF);
        foreach (RA[i]) begin
            v = (RA[i] == OFS_U_DIR || RA[i] == OFS_C_DIR) ? RST_DIR : RST_ZERO;
            rchk(RA[i], v);
        end
        lat = RST_LATCH;
        // plain port, random directions, latch kept across direction changes
        for (int n = 0; n < 40; n++) begin
            dir = 16'($urandom());
            v = 16'($urandom());
            @(posedge clk);
            u_val <= 16'($urandom());
            wr(OFS_U_DIR, dir);
            c16(up_pin_oe, ~dir);
            c16(up_pin_out & ~dir, lat & ~dir);
            wr(OFS_U_LATCH, v);
            lat = v;
            c16(up_pin_oe, ~dir);
            c16(up_pin_in & dir, u_val & dir);
            c16(up_pin_out & ~dir, lat & ~dir);
            rchk(OFS_U_LATCH, port_rd(lat, dir, u_val));
            c16(up_pin_out & ~dir, lat & ~dir);
        end
        // read-modify-write in output mode
        wr(OFS_U_DIR, 16'h0000);
        rchk(OFS_U_LATCH, lat);
        wr(OFS_U_LATCH, lat + 16'h0001);
        c16(up_pin_out, lat + 16'h0001);
        // bit operation on a mixed port writes the whole word back
        wr(OFS_U_DIR, 16'h00FF);
        v = port_rd(lat + 16'h0001, 16'h00FF, u_val) ^ 16'h0100;
        rchk(OFS_U_LATCH, port_rd(lat + 16'h0001, 16'h00FF, u_val));
        wr(OFS_U_LATCH, v);
        c16(up_pin_oe, 16'hFF00);
        c16(up_pin_in, {v[15:8], u_val[7:0]});
        // external interrupt inputs on the top three pins
        wr(OFS_U_DIR, RST_DIR);
        @(posedge clk);
        u_val <= 16'($urandom()) & 16'h1FFF;
        wr(OFS_U_RISE, 16'hE000);
        rchk(OFS_U_LATCH, u_val);
        wr(OFS_U_ODRAIN, 16'h1800);
        wr(OFS_U_FUNC, 16'hFFFF);
        wr(OFS_U_MODE, 16'hFFFF);
        edge3(3'h7, 3'h7);
        rchk(OFS_IRQ_FLAG, 16'h0007);
        wr(OFS_IRQ_FLAG, 16'h0007);
        rchk(OFS_IRQ_FLAG, 16'h0000);
        edge3(3'h0, 3'h0);
        wr(OFS_U_RISE, 16'h0000);
        wr(OFS_U_FALL, 16'hE000);
        edge3(3'h7, 3'h0);
        edge3(3'h0, 3'h7);
        // serial channel ignores the open-drain bits
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            {csi_b_serial_out, csi_b_serial_clock_out, csi_b_serial_clock_oe} <= 3'($urandom());
            #1;
            chk(36'({up_pin_oe[12:11], up_pin_out[11], csi_b_serial_in, csi_b_serial_clock_in}),
                36'({csi_b_serial_clock_oe, 2'h3 & {1'b1, csi_b_serial_out}, u_val[10],
                csi_b_serial_clock_oe ? csi_b_serial_clock_out : u_val[12]}));
        end
        // address outputs override latch and direction; whole-word setup
        wr(OFS_U_LATCH, 16'($urandom()));
        wr(OFS_U_ODRAIN, 16'h0000);
        wr(OFS_U_FUNC, 16'h0000);
        wr(OFS_U_MODE, 16'hFFFF);
        @(posedge clk);
        addr_low_out <= 16'($urandom());
        #1 c16(up_pin_out, addr_low_out);
        c16(up_pin_oe, 16'hFFFF);
        // bus-control pins: plain output first, then handed to the bus side
        r = 36'({$urandom(), $urandom()});
        wctrl(OFS_C_DIR, 36'h0);
        wctrl(OFS_C_LATCH, r);
        chk(ctrl_pin_out, r);
        chk(ctrl_pin_oe, {CTRL_PINS{1'b1}});
        rchk(OFS_C_LATCH, r[15:0]);
        @(posedge clk);
        bus_alt_out <= 36'({$urandom(), $urandom()});
        bus_alt_oe <= 36'({$urandom(), $urandom()});
        c_val <= 36'({$urandom(), $urandom()});
        wctrl(OFS_C_MODE, {CTRL_PINS{1'b1}});
        chk(ctrl_pin_out & bus_alt_oe, bus_alt_out & bus_alt_oe);
        chk(ctrl_pin_oe, bus_alt_oe);
        chk(bus_alt_in, (bus_alt_oe & bus_alt_out) | (~bus_alt_oe & c_val));
        test_done();
    end
endmodule
`default_nettype wire
